// ==== mmu_tlb_pkg.sv ====
// Shared constants and types for the TLB fault and management block
package mmu_tlb_pkg;
  // Array geometry
  localparam int ENTRIES = 64;
  localparam int IDX_W = 6;
  localparam int PAGE_W = 22;
  localparam int IDENT_W = 8;
  localparam int ZONE_COUNT = 16;
  localparam int ZONE_SEL_W = 4;
  // Tag half field positions; valid sits clear of the identifier so identifier zero can be valid
  localparam int TAG_EPN_LSB = 10;
  localparam int TAG_VALID_BIT = 9;
  localparam int TAG_IDENT_LSB = 0;
  // Data half field positions
  localparam int DATA_RPN_LSB = 10;
  localparam int DATA_EXEC_BIT = 9;
  localparam int DATA_WRITE_BIT = 8;
  localparam int DATA_ZONE_LSB = 4;
  localparam int DATA_GUARD_BIT = 0;
  // Search result index lands in register bits 26:31 (low six bits)
  localparam int SEARCH_IDX_LSB = 0;
  // Zone field encodings
  localparam logic [1:0] ZONE_NONE = 2'h0;
  localparam logic [1:0] ZONE_PAGE_B = 2'h2;
  localparam logic [1:0] ZONE_FULL = 2'h3;
  // Reset values
  localparam logic [31:0] WORD_RESET = 32'h00000000;
  localparam logic [1:0] ENABLE_RESET = 2'h0;

  // Data access kinds from the execute unit
  typedef enum logic [3:0] {
    ACC_LOAD, ACC_STORE, ACC_ICBI, ACC_DCBZ, ACC_DCBF, ACC_DCBT, ACC_DCBTST,
    ACC_DCBI, ACC_DCCCI, ACC_DCBA
  } access_kind_type;

  // Management operations
  typedef enum logic [2:0] {
    OP_NONE, OP_SEARCH, OP_READ_TAG, OP_READ_DATA, OP_WRITE_TAG, OP_WRITE_DATA, OP_INVAL_ALL, OP_SYNC
  } mgmt_op_type;

  // Data access outcomes
  typedef enum logic [2:0] {
    DRES_OK, DRES_NOP, DRES_STORAGE, DRES_PROGRAM, DRES_MISS
  } data_result_type;
endpackage : mmu_tlb_pkg

// ==== tlb_lookup.sv ====
// Fully associative match over the unified translation array
`timescale 1ns/100ps
module tlb_lookup #(
  parameter int ENTRIES = mmu_tlb_pkg::ENTRIES,
  parameter int IDX_W = mmu_tlb_pkg::IDX_W
) (
  input wire logic [31:0] effective_address,
  input wire logic [7:0] process_identifier,
  input wire logic [ENTRIES*32-1:0] tags,
  output logic hit,
  output logic [IDX_W-1:0] hit_idx
);
  initial
  begin
    if (ENTRIES > (1 << IDX_W)) $error("tlb_lookup: index too narrow");
  end

  logic [ENTRIES-1:0] match;

  // Per-entry compare: valid, page number and identifier (0 matches all)
  genvar g;
  generate
    for (g = 0; g < ENTRIES; g++)
    begin : g_cmp
      logic [31:0] t;
      logic [7:0] ident;
      assign t = tags[g*32 +: 32];
      assign ident = t[mmu_tlb_pkg::TAG_IDENT_LSB +: mmu_tlb_pkg::IDENT_W];
      assign match[g] = t[mmu_tlb_pkg::TAG_VALID_BIT] &&
        (t[31:mmu_tlb_pkg::TAG_EPN_LSB] == effective_address[31:mmu_tlb_pkg::TAG_EPN_LSB]) &&
        ((ident == 8'h00) || (ident == process_identifier));
    end
  endgenerate

  // Lowest matching index wins; software keeps entries unique
  always_comb
  begin
    hit = 1'b0;
    hit_idx = '0;
    for (int i = ENTRIES - 1; i >= 0; i--)
    begin
      if (match[i])
      begin
        hit = 1'b1;
        hit_idx = IDX_W'(i);
      end
    end
  end
endmodule : tlb_lookup

// ==== zone_check.sv ====
// Zone and page permission evaluation for one matched entry
`timescale 1ns/100ps
module zone_check (
  input wire logic [31:0] zone_protection_reg,
  input wire logic [3:0] zone_select,
  input wire logic problem_state,
  output logic [1:0] zone_access_field,
  output logic no_access,
  output logic write_granted,
  output logic exec_granted
);
  // Zone 0 sits in the top two bits, zone 15 in the bottom two
  always_comb
  begin
    zone_access_field = zone_protection_reg[(5'd30 - {zone_select, 1'b0}) +: 2];
    no_access = problem_state && (zone_access_field == mmu_tlb_pkg::ZONE_NONE);
    if (problem_state)
      write_granted = (zone_access_field == mmu_tlb_pkg::ZONE_FULL);
    else
      write_granted = (zone_access_field == mmu_tlb_pkg::ZONE_FULL) ||
        (zone_access_field == mmu_tlb_pkg::ZONE_PAGE_B);
    exec_granted = write_granted;
  end
endmodule : zone_check

// ==== mmu_tlb_fault_and_management.sv ====
// Protection checks, miss detection and management operations of the MMU TLB
// Summary of operation
// - Interrupt taken clears both translation enables
// - Translation off passes address, skips checks
// - Problem state zone 00 faults data accesses other than privileged invalidates, touches and block allocate
// - Touch instructions no-op under zone 00
// - Problem store to read-only page faults unless 11
// - Problem-state privileged invalidates to read-only page report program interrupt unless 11
// - Supervisor store read-only faults unless 11/10
// - Block allocate never takes a storage fault, becomes no-op
// - Problem state execute from zone 00 faults
// - Non-executable page faults unless zone overrides
// - Execute from guarded page faults
// - Data miss when no valid match; touch instructions no-op instead
// - Instruction miss only on attempted execution
// - Miss address saved to save or fault register
// - Search writes matching index to bits 26:31
// - Recording search sets equal bit by hit
// - Read and write tag or data halves
// - Invalidate-all clears only valid bits
// - Write with valid zero invalidates entry
// - Sync completes with no effect
// - No reference or change bits kept
// - No hardware table walk or replacement
// - Zone select picks zone field
// - Identifier zero matches any process
`timescale 1ns/100ps
module mmu_tlb_fault_and_management #(
  parameter int ENTRIES = mmu_tlb_pkg::ENTRIES,
  parameter int IDX_W = mmu_tlb_pkg::IDX_W
) (
  input wire logic clk,
  input wire logic nrst,
  // Translation state from the core
  input wire logic interrupt_taken,
  input wire logic set_enables,
  input wire logic [1:0] enables_value,
  input wire logic problem_state,
  input wire logic [7:0] process_identifier,
  input wire logic [31:0] zone_protection_reg,
  // Fetch side: execution attempt of a fetched instruction
  input wire logic fetch_exec,
  input wire logic [31:0] fetch_address,
  // Data side access
  input wire logic data_req,
  input wire mmu_tlb_pkg::access_kind_type data_kind,
  input wire logic [31:0] data_address,
  // Management operations
  input wire mmu_tlb_pkg::mgmt_op_type mgmt_op,
  input wire logic mgmt_record,
  input wire logic [IDX_W-1:0] mgmt_index,
  input wire logic [31:0] mgmt_base,
  input wire logic mgmt_base_zero,
  input wire logic [31:0] mgmt_offset,
  input wire logic [31:0] mgmt_wdata,
  // Outputs
  output logic instr_translate_enable,
  output logic data_translate_enable,
  output logic [31:0] fetch_real_address,
  output logic instr_storage_int,
  output logic instr_miss_int,
  output logic [31:0] data_real_address,
  output logic data_done,
  output logic data_nop,
  output logic data_storage_int,
  output logic program_int,
  output logic data_miss_int,
  output logic [31:0] save_restore_zero,
  output logic [31:0] data_fault_address_reg,
  output logic mgmt_done,
  output logic [31:0] mgmt_rdata,
  output logic cond_field_zero_equal,
  output logic cond_valid
);
  initial
  begin
    if (ENTRIES > (1 << IDX_W) || ENTRIES < 1) $error("mmu_tlb: bad ENTRIES");
  end

  // Two halves of each entry; software alone loads them
  logic [31:0] tag_q [ENTRIES];
  logic [31:0] data_q [ENTRIES];
  logic [ENTRIES*32-1:0] tag_flat;

  always_comb
  begin
    for (int i = 0; i < ENTRIES; i++)
      tag_flat[i*32 +: 32] = tag_q[i];
  end

  // Three lookups: fetch, data, search
  logic f_hit, d_hit, s_hit;
  logic [IDX_W-1:0] f_idx, d_idx, s_idx;
  logic [31:0] search_address;
  assign search_address = (mgmt_base_zero ? 32'h00000000 : mgmt_base) + mgmt_offset;

  tlb_lookup #(.ENTRIES(ENTRIES), .IDX_W(IDX_W)) u_fetch_lu (
    .effective_address(fetch_address),
    .process_identifier(process_identifier),
    .tags(tag_flat),
    .hit(f_hit),
    .hit_idx(f_idx)
  );
  tlb_lookup #(.ENTRIES(ENTRIES), .IDX_W(IDX_W)) u_data_lu (
    .effective_address(data_address),
    .process_identifier(process_identifier),
    .tags(tag_flat),
    .hit(d_hit),
    .hit_idx(d_idx)
  );
  tlb_lookup #(.ENTRIES(ENTRIES), .IDX_W(IDX_W)) u_search_lu (
    .effective_address(search_address),
    .process_identifier(process_identifier),
    .tags(tag_flat),
    .hit(s_hit),
    .hit_idx(s_idx)
  );

  // Zone evaluation on the single matched entry of each side
  logic [31:0] f_data, d_data;
  assign f_data = data_q[f_idx];
  assign d_data = data_q[d_idx];
  logic f_none, f_xok, d_none, d_wok;
  logic [1:0] f_zone, d_zone;

  zone_check u_fetch_zone (
    .zone_protection_reg(zone_protection_reg),
    .zone_select(f_data[mmu_tlb_pkg::DATA_ZONE_LSB +: mmu_tlb_pkg::ZONE_SEL_W]),
    .problem_state(problem_state),
    .zone_access_field(f_zone),
    .no_access(f_none),
    .write_granted(),
    .exec_granted(f_xok)
  );
  zone_check u_data_zone (
    .zone_protection_reg(zone_protection_reg),
    .zone_select(d_data[mmu_tlb_pkg::DATA_ZONE_LSB +: mmu_tlb_pkg::ZONE_SEL_W]),
    .problem_state(problem_state),
    .zone_access_field(d_zone),
    .no_access(d_none),
    .write_granted(d_wok),
    .exec_granted()
  );

  // Translation enables: interrupt entry wins over a software update
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      instr_translate_enable <= 1'b0;
      data_translate_enable <= 1'b0;
    end
    else if (interrupt_taken)
    begin
      instr_translate_enable <= 1'b0;
      data_translate_enable <= 1'b0;
    end
    else if (set_enables)
    begin
      instr_translate_enable <= enables_value[1];
      data_translate_enable <= enables_value[0];
    end
  end

  // Fetch side classification
  logic [31:0] f_real;
  logic f_storage, f_miss;
  always_comb
  begin
    f_real = fetch_address;
    f_storage = 1'b0;
    f_miss = 1'b0;
    if (instr_translate_enable)
    begin
      if (!f_hit)
        f_miss = 1'b1;
      else
      begin
        f_real = {f_data[31:mmu_tlb_pkg::DATA_RPN_LSB], fetch_address[mmu_tlb_pkg::DATA_RPN_LSB-1:0]};
        f_storage = f_none ||
          (!f_data[mmu_tlb_pkg::DATA_EXEC_BIT] && !f_xok) ||
          f_data[mmu_tlb_pkg::DATA_GUARD_BIT];
      end
    end
  end

  // Fetch outputs registered; faults only on an execution attempt
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      fetch_real_address <= mmu_tlb_pkg::WORD_RESET;
      instr_storage_int <= 1'b0;
      instr_miss_int <= 1'b0;
      save_restore_zero <= mmu_tlb_pkg::WORD_RESET;
    end
    else
    begin
      fetch_real_address <= f_real;
      instr_storage_int <= fetch_exec && f_storage;
      instr_miss_int <= fetch_exec && f_miss;
      if (fetch_exec && f_miss)
        save_restore_zero <= fetch_address;
    end
  end

  // Data side classification
  logic is_touch, is_store_like, is_priv;
  logic [31:0] d_real;
  mmu_tlb_pkg::data_result_type d_res;
  always_comb
  begin
    is_touch = (data_kind == mmu_tlb_pkg::ACC_DCBT) || (data_kind == mmu_tlb_pkg::ACC_DCBTST);
    is_priv = (data_kind == mmu_tlb_pkg::ACC_DCBI) || (data_kind == mmu_tlb_pkg::ACC_DCCCI);
    is_store_like = (data_kind == mmu_tlb_pkg::ACC_STORE) || (data_kind == mmu_tlb_pkg::ACC_DCBZ) || is_priv;
    d_real = data_address;
    d_res = mmu_tlb_pkg::DRES_OK;
    if (data_translate_enable)
    begin
      d_real = {d_data[31:mmu_tlb_pkg::DATA_RPN_LSB], data_address[mmu_tlb_pkg::DATA_RPN_LSB-1:0]};
      if (!d_hit)
        d_res = is_touch ? mmu_tlb_pkg::DRES_NOP : mmu_tlb_pkg::DRES_MISS;
      else if (d_none && !is_priv)
        d_res = is_touch ? mmu_tlb_pkg::DRES_NOP : mmu_tlb_pkg::DRES_STORAGE;
      else if (is_store_like && !d_data[mmu_tlb_pkg::DATA_WRITE_BIT] && !d_wok)
      begin
        if (problem_state && is_priv)
          d_res = mmu_tlb_pkg::DRES_PROGRAM;
        else
          d_res = mmu_tlb_pkg::DRES_STORAGE;
      end
      // Block allocate turns any storage fault into a no-op
      if (data_kind == mmu_tlb_pkg::ACC_DCBA && d_res == mmu_tlb_pkg::DRES_STORAGE)
        d_res = mmu_tlb_pkg::DRES_NOP;
    end
  end

  // Data outputs registered, one pulse per request
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      data_real_address <= mmu_tlb_pkg::WORD_RESET;
      data_done <= 1'b0;
      data_nop <= 1'b0;
      data_storage_int <= 1'b0;
      program_int <= 1'b0;
      data_miss_int <= 1'b0;
      data_fault_address_reg <= mmu_tlb_pkg::WORD_RESET;
    end
    else
    begin
      data_real_address <= d_real;
      data_done <= data_req && (d_res == mmu_tlb_pkg::DRES_OK);
      data_nop <= data_req && (d_res == mmu_tlb_pkg::DRES_NOP);
      data_storage_int <= data_req && (d_res == mmu_tlb_pkg::DRES_STORAGE);
      program_int <= data_req && (d_res == mmu_tlb_pkg::DRES_PROGRAM);
      data_miss_int <= data_req && (d_res == mmu_tlb_pkg::DRES_MISS);
      if (data_req && d_res == mmu_tlb_pkg::DRES_MISS)
        data_fault_address_reg <= data_address;
    end
  end

  // Array updates: only management writes touch it, never hardware refill
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      for (int i = 0; i < ENTRIES; i++)
      begin
        tag_q[i] <= mmu_tlb_pkg::WORD_RESET;
        data_q[i] <= mmu_tlb_pkg::WORD_RESET;
      end
    end
    else
    begin
      case (mgmt_op)
        mmu_tlb_pkg::OP_WRITE_TAG: tag_q[mgmt_index] <= mgmt_wdata;
        mmu_tlb_pkg::OP_WRITE_DATA: data_q[mgmt_index] <= mgmt_wdata;
        mmu_tlb_pkg::OP_INVAL_ALL:
        begin
          for (int i = 0; i < ENTRIES; i++)
            tag_q[i][mmu_tlb_pkg::TAG_VALID_BIT] <= 1'b0;
        end
        default:
        begin
        end
      endcase
    end
  end

  // Management answers; sync simply completes (no reference/change bits kept)
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      mgmt_done <= 1'b0;
      mgmt_rdata <= mmu_tlb_pkg::WORD_RESET;
      cond_field_zero_equal <= 1'b0;
      cond_valid <= 1'b0;
    end
    else
    begin
      mgmt_done <= (mgmt_op != mmu_tlb_pkg::OP_NONE);
      cond_valid <= (mgmt_op == mmu_tlb_pkg::OP_SEARCH) && mgmt_record;
      case (mgmt_op)
        mmu_tlb_pkg::OP_SEARCH:
        begin
          if (s_hit)
            mgmt_rdata <= {{(32-IDX_W){1'b0}}, s_idx};
          if (mgmt_record)
            cond_field_zero_equal <= s_hit;
        end
        mmu_tlb_pkg::OP_READ_TAG: mgmt_rdata <= tag_q[mgmt_index];
        mmu_tlb_pkg::OP_READ_DATA: mgmt_rdata <= data_q[mgmt_index];
        default:
        begin
        end
      endcase
    end
  end

  // Checks
  chk_irq_clears: assert property (@(posedge clk) disable iff (!nrst)
    interrupt_taken |=> !instr_translate_enable && !data_translate_enable) else $error("enables not cleared");
  chk_real_pass: assert property (@(posedge clk) disable iff (!nrst)
    !data_translate_enable |=> data_real_address == $past(data_address) && !data_storage_int && !data_miss_int)
    else $error("real mode not passed");
  chk_touch_nop: assert property (@(posedge clk) disable iff (!nrst)
    data_req && is_touch |=> !data_storage_int && !data_miss_int) else $error("touch faulted");
  chk_dcba_quiet: assert property (@(posedge clk) disable iff (!nrst)
    data_req && data_kind == mmu_tlb_pkg::ACC_DCBA |=> !data_storage_int) else $error("dcba faulted");
  chk_guard_fault: assert property (@(posedge clk) disable iff (!nrst)
    fetch_exec && instr_translate_enable && f_hit && f_data[mmu_tlb_pkg::DATA_GUARD_BIT] |=> instr_storage_int)
    else $error("guarded exec missed");
  chk_dmiss_addr: assert property (@(posedge clk) disable iff (!nrst)
    data_miss_int |-> data_fault_address_reg == $past(data_address)) else $error("miss address");
  chk_imiss_exec: assert property (@(posedge clk) disable iff (!nrst)
    instr_miss_int |-> $past(fetch_exec)) else $error("miss without exec");
  chk_search_eq: assert property (@(posedge clk) disable iff (!nrst)
    mgmt_op == mmu_tlb_pkg::OP_SEARCH && mgmt_record |=> cond_valid && cond_field_zero_equal == $past(s_hit))
    else $error("search equal bit");
  chk_problem_zone: assert property (@(posedge clk) disable iff (!nrst)
    data_req && data_translate_enable && d_hit && d_none && data_kind == mmu_tlb_pkg::ACC_LOAD |=> data_storage_int)
    else $error("zone 00 load");
  // Full-access zone overrides page write permission in both states
  chk_full_zone_data: assert property (@(posedge clk) disable iff (!nrst)
    data_req && d_hit && d_zone == mmu_tlb_pkg::ZONE_FULL |=> !data_storage_int && !program_int)
    else $error("full zone data fault");
  chk_full_zone_exec: assert property (@(posedge clk) disable iff (!nrst)
    fetch_exec && f_hit && f_zone == mmu_tlb_pkg::ZONE_FULL && !f_data[mmu_tlb_pkg::DATA_GUARD_BIT]
    |=> !instr_storage_int) else $error("full zone exec fault");
endmodule : mmu_tlb_fault_and_management

// ==== core_lsu_model.sv ====
// Core load/store unit model: issues data accesses and audits one outcome per access
`timescale 1ns/100ps
module core_lsu_model (
  input wire logic clk,
  input wire logic go,
  input wire mmu_tlb_pkg::access_kind_type kind_in,
  input wire logic [31:0] addr_in,
  input wire logic [4:0] outcome,
  output logic data_req,
  output mmu_tlb_pkg::access_kind_type data_kind,
  output logic [31:0] data_address,
  output int faults
);
  logic pend;
  mmu_tlb_pkg::access_kind_type kind_p;
  logic [31:0] addr_p;
  // Start idle so nothing is launched before reset is released
  initial
  begin
    pend = 1'b0;
    faults = 0;
    data_req = 1'b0;
    data_kind = mmu_tlb_pkg::ACC_LOAD;
    data_address = 32'h00000000;
  end
  // Commands are taken on the rising edge so the bench never races the launch
  always @(posedge clk)
  begin
    pend <= go;
    kind_p <= kind_in;
    addr_p <= addr_in;
  end
  // Launch on the falling edge; an idle address toggles so a stale value never looks valid
  always @(negedge clk)
  begin
    // The access launched one falling edge ago was taken at the rising edge just passed
    if ($countones(outcome) != (data_req ? 1 : 0))
      faults <= faults + 1;
    data_req <= pend;
    data_kind <= kind_p;
    data_address <= pend ? addr_p : ~data_address;
  end
endmodule : core_lsu_model

// ==== testbench.sv ====
// Self-checking bench for the TLB fault and management block
`timescale 1ns/100ps
module testbench;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic interrupt_taken = 1'b0;
  logic set_enables = 1'b0;
  logic [1:0] enables_value = 2'h0;
  logic problem_state = 1'b0;
  logic [7:0] process_identifier = 8'h40;
  logic [31:0] zone_protection_reg = 32'h00000000;
  logic fetch_exec = 1'b0;
  logic [31:0] fetch_address = 32'h00000000;
  logic go = 1'b0;
  mmu_tlb_pkg::access_kind_type kind_in = mmu_tlb_pkg::ACC_LOAD;
  logic [31:0] addr_in = 32'h00000000;
  mmu_tlb_pkg::mgmt_op_type mgmt_op = mmu_tlb_pkg::OP_NONE;
  logic mgmt_record = 1'b0;
  logic [5:0] mgmt_index = 6'h00;
  logic [31:0] mgmt_base = 32'h00000000;
  logic mgmt_base_zero = 1'b0;
  logic [31:0] mgmt_offset = 32'h00000000;
  logic [31:0] mgmt_wdata = 32'h00000000;
  logic data_req, data_done, data_nop, data_storage_int, program_int, data_miss_int;
  mmu_tlb_pkg::access_kind_type data_kind;
  logic [31:0] data_address, fetch_real_address, data_real_address, save_restore_zero, data_fault_address_reg;
  logic instr_translate_enable, data_translate_enable, instr_storage_int, instr_miss_int;
  logic mgmt_done, cond_field_zero_equal, cond_valid;
  logic [31:0] mgmt_rdata;
  int mismatches = 0;
  int samples_checked = 0;
  int faults;
  int xp;
  logic [7:0] seed = 8'h3E;
  // Page 0 is mapped only briefly through entry 3; entries 1 and 2 map pages 1 and 2
  logic [21:0] pg [3] = '{22'h3FFFFF, 22'h00ABC, 22'h12345};
  logic [21:0] rpn [3] = '{22'h000000, 22'h3C001, 22'h20FF0};
  logic [9:0] lo [3] = '{10'h000, 10'h010, 10'h321};

  always #12.5 clk = ~clk;

  mmu_tlb_fault_and_management u_mmu_tlb_fault_and_management (
    .clk, .nrst, .interrupt_taken, .set_enables, .enables_value, .problem_state, .process_identifier,
    .zone_protection_reg, .fetch_exec, .fetch_address, .data_req, .data_kind, .data_address, .mgmt_op,
    .mgmt_record, .mgmt_index, .mgmt_base, .mgmt_base_zero, .mgmt_offset, .mgmt_wdata,
    .instr_translate_enable, .data_translate_enable, .fetch_real_address, .instr_storage_int,
    .instr_miss_int, .data_real_address, .data_done, .data_nop, .data_storage_int, .program_int,
    .data_miss_int, .save_restore_zero, .data_fault_address_reg, .mgmt_done, .mgmt_rdata,
    .cond_field_zero_equal, .cond_valid
  );

  core_lsu_model u_core_lsu_model (
    .clk, .go, .kind_in, .addr_in, .data_req, .data_kind, .data_address, .faults,
    .outcome({data_done, data_nop, data_storage_int, program_int, data_miss_int})
  );

  function automatic logic [7:0] nxt(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : nxt

  // Expected outcome: 0 done, 1 nop, 2 storage, 3 program, 4 miss; block allocate is no store
  function automatic int exp_d(input int k, input int z, input int p, input bit h, input bit w);
    bit st;
    bit tch;
    st = k == 1 || k == 3 || k == 7 || k == 8;
    tch = k == 5 || k == 6;
    if (!h)
      return tch ? 1 : 4;
    if (p != 0 && z == 0 && (k == 9 || k < 7))
      return (tch || k == 9) ? 1 : 2;
    if (st && !w && (p != 0 ? z != 3 : z < 2))
      return (p != 0 && k > 6) ? 3 : 2;
    return 0;
  endfunction : exp_d

  task automatic chk(input logic ok, input string m);
    samples_checked++;
    if (ok !== 1'b1)
    begin
      mismatches++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask : chk

  // Every task starts and ends on a falling edge, where inputs change
  task automatic dacc(input int k, input int e, input int x, input bit on);
    logic [31:0] a;
    seed = nxt(seed);
    a = {pg[e], seed, 2'h1};
    go = 1'b1;
    kind_in = mmu_tlb_pkg::access_kind_type'(k);
    addr_in = a;
    @(negedge clk);
    go = 1'b0;
    @(negedge clk);
    if (x >= 0)
      chk({data_done, data_nop, data_storage_int, program_int, data_miss_int} === (5'h10 >> x), "data outcome");
    if (x == 0)
      chk(data_real_address === (on ? {rpn[e], a[9:0]} : a), "real address");
    if (x == 4)
      chk(data_fault_address_reg === a, "data miss address");
  endtask : dacc

  task automatic fetch(input int e, input logic isi, input logic ms);
    logic [31:0] a;
    seed = nxt(seed);
    a = {pg[e], 2'h2, seed};
    fetch_exec = 1'b1;
    fetch_address = a;
    @(negedge clk);
    fetch_exec = 1'b0;
    chk(instr_storage_int === isi && instr_miss_int === ms, "fetch outcome");
    if (ms)
      chk(save_restore_zero === a, "fetch miss address");
  endtask : fetch

  task automatic mop(input mmu_tlb_pkg::mgmt_op_type op, input int ix, input logic [31:0] w);
    // One idle edge first, so the strobe is never lowered and raised in one time step
    @(negedge clk);
    mgmt_op = op;
    mgmt_index = ix[5:0];
    mgmt_wdata = w;
    mgmt_record = op == mmu_tlb_pkg::OP_SEARCH;
    @(negedge clk);
    mgmt_op = mmu_tlb_pkg::OP_NONE;
    chk(mgmt_done === 1'b1, "management done");
  endtask : mop

  task automatic srch(input logic bz, input logic [31:0] b, input logic [31:0] o, input logic h, input int ix);
    mgmt_base_zero = bz;
    mgmt_base = b;
    mgmt_offset = o;
    mop(mmu_tlb_pkg::OP_SEARCH, 0, 32'h00000000);
    chk(cond_valid === 1'b1 && cond_field_zero_equal === h, "search flag");
    if (h)
      chk(mgmt_rdata[5:0] === ix[5:0], "search index");
  endtask : srch

  task automatic en(input logic [1:0] v);
    set_enables = 1'b1;
    enables_value = v;
    @(negedge clk);
    set_enables = 1'b0;
  endtask : en

  task automatic finish_test;
    mismatches += faults;
    $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : finish_test

  // The whole sequence needs well under a thousand cycles
  initial
  begin
    repeat (20000) @(posedge clk);
    mismatches++;
    $display("[FAIL] %0t watchdog expired", $time);
    finish_test;
  end

  initial
  begin
    repeat (16) @(negedge clk);
    nrst = 1'b1;
    chk({instr_translate_enable, data_translate_enable, mgmt_rdata} === 34'h0, "reset values");
    for (int e = 1; e < 3; e++)
    begin
      mop(mmu_tlb_pkg::OP_WRITE_TAG, e, {pg[e], 10'h240});
      mop(mmu_tlb_pkg::OP_WRITE_DATA, e, {rpn[e], lo[e]});
    end
    mop(mmu_tlb_pkg::OP_READ_TAG, 2, 32'h0);
    chk(mgmt_rdata === {pg[2], 10'h240}, "tag readback");
    mop(mmu_tlb_pkg::OP_READ_DATA, 1, 32'h0);
    chk(mgmt_rdata === {rpn[1], lo[1]}, "data readback");
    srch(1'b0, {pg[1], 10'h000}, 32'h00000017, 1'b1, 1);
    srch(1'b1, 32'hFFFFFFFF, {pg[2], 10'h2A5}, 1'b1, 2);
    srch(1'b0, {pg[0], 10'h000}, 32'h00000003, 1'b0, 0);
    // Single-entry invalidate through a write with the valid bit low
    mop(mmu_tlb_pkg::OP_WRITE_TAG, 3, {pg[0], 10'h240});
    srch(1'b0, {pg[0], 10'h000}, 32'h00000000, 1'b1, 3);
    mop(mmu_tlb_pkg::OP_WRITE_TAG, 3, {pg[0], 10'h040});
    srch(1'b0, {pg[0], 10'h000}, 32'h00000000, 1'b0, 0);
    mop(mmu_tlb_pkg::OP_SYNC, 0, 32'h0);
    srch(1'b0, {pg[1], 10'h000}, 32'h00000000, 1'b1, 1);
    en(2'h3);
    chk(instr_translate_enable === 1'b1 && data_translate_enable === 1'b1, "enables set");
    // Every kind against every zone value, both states, miss, read-only and writable pages
    for (int e = 0; e < 3; e++)
      for (int z = 0; z < 4; z++)
        for (int p = 0; p < 2; p++)
        begin
          seed = nxt(seed);
          zone_protection_reg = {4{seed}};
          zone_protection_reg[31 - 2 * e -: 2] = z[1:0];
          problem_state = p[0];
          for (int k = 0; k < 10; k++)
          begin
            xp = exp_d(k, z, p, e != 0, e == 2);
            dacc(k, e, xp, 1'b1);
          end
          fetch(e, e == 2 || (e == 1 && (p != 0 ? z != 3 : z < 2)), e == 0);
        end
    process_identifier = 8'h41;
    dacc(0, 1, 4, 1'b1);
    // Identifier zero must match a foreign process
    mop(mmu_tlb_pkg::OP_WRITE_TAG, 1, {pg[1], 10'h200});
    zone_protection_reg = 32'hFFFFFFFF;
    dacc(0, 1, 0, 1'b1);
    process_identifier = 8'h40;
    // Interrupt wins over a simultaneous enable load
    interrupt_taken = 1'b1;
    set_enables = 1'b1;
    enables_value = 2'h3;
    @(negedge clk);
    interrupt_taken = 1'b0;
    set_enables = 1'b0;
    chk(instr_translate_enable === 1'b0 && data_translate_enable === 1'b0, "interrupt clears");
    problem_state = 1'b1;
    zone_protection_reg = 32'h00000000;
    for (int k = 0; k < 10; k++)
      dacc(k, k % 3, 0, 1'b0);
    fetch(0, 1'b0, 1'b0);
    chk(fetch_real_address === fetch_address, "fetch real address");
    mop(mmu_tlb_pkg::OP_INVAL_ALL, 0, 32'h0);
    mop(mmu_tlb_pkg::OP_READ_TAG, 1, 32'h0);
    chk(mgmt_rdata === {pg[1], 10'h000}, "invalidate keeps fields");
    en(2'h3);
    srch(1'b0, {pg[2], 10'h000}, 32'h00000000, 1'b0, 0);
    dacc(0, 2, 4, 1'b1);
    finish_test;
  end
endmodule : testbench
